// File: hdl/shpe_pkg.sv
// shpe_pkg: constants and types of the slot reset and hot-plug event block.
// assumes a 20 MHz core clock and a word-wide classic Wishbone bus.
package shpe_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_NS       = 1000;
  localparam int STEP_CYC      = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_RST_NS    = 200000;
  localparam int MIN_RST_CYC   =
    (MIN_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // widths
  localparam int NEV   = 6;
  localparam int DLY_W = 8;
  localparam int CNT_W = 16;
  localparam int PID_W = 4;

  // register byte offsets
  localparam logic [11:0] OFS_HP_CFG    = 12'h000;
  localparam logic [11:0] OFS_GE_CTL    = 12'h004;
  localparam logic [11:0] OFS_GE_STS    = 12'h008;
  localparam logic [11:0] OFS_PORT_BASE = 12'h100;
  // word index inside a 16-byte port block
  localparam logic [1:0]  SUB_SLOT_CTL  = 2'h0;
  localparam logic [1:0]  SUB_SLOT_STS  = 2'h1;
  localparam logic [1:0]  SUB_FUNC      = 2'h2;
  localparam logic [1:0]  SUB_STATE     = 2'h3;

  // hotplug_config_reg fields
  localparam int CFG_MODE_BIT   = 0;
  localparam int CFG_P2R_LSB    = 8;
  localparam int CFG_R2P_LSB    = 16;
  localparam int CFG_GEALT_BIT  = 24;
  // slot_control_reg fields; event enables sit in [5:0]
  localparam int CTL_HOTPLUG_IRQ_ENABLE_BIT   = 6;
  localparam int CTL_PWROFF_BIT = 10;
  // function word fields
  localparam int FN_MSI_BIT     = 0;
  localparam int FN_LEGACY_IRQ_DISABLE_BIT   = 1;
  localparam int FN_WAKE_BIT    = 2;
  localparam int FN_PS_LSB      = 4;
  localparam int FN_PART_LSB    = 8;
  // state word fields
  localparam int ST_PE_BIT      = 0;
  localparam int ST_RSTN_BIT    = 1;
  localparam int ST_PG_BIT      = 2;

  // reset values and field encodings
  localparam logic [DLY_W-1:0] P2R_RST = 8'h01;
  localparam logic [DLY_W-1:0] R2P_RST = 8'h01;
  localparam logic [1:0]       PS_D0    = 2'h0;
  localparam logic [1:0]       PS_D3HOT = 2'h3;
  localparam logic             MODE_PE  = 1'b0;
  localparam logic             MODE_PG  = 1'b1;

  typedef enum {SEQ_OFF, SEQ_PWR_UP, SEQ_ON, SEQ_PWR_DN} shpe_seq_type;

endpackage

// File: hdl/shpe_seq.sv
// shpe_seq: power enable / port reset sequencer for one downstream port.
// assumes synchronous inputs; delays are counted in STEP_NS units.
`timescale 1ns/1ps
module shpe_seq
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  // control from the register core
  shpe_seq_if.seq   bus
);

  shpe_pkg::shpe_seq_type     state_reg;
  logic [shpe_pkg::CNT_W-1:0] cnt_reg;
  logic [shpe_pkg::CNT_W-1:0] pulse_reg;
  logic [shpe_pkg::CNT_W-1:0] p2r_cyc;
  logic [shpe_pkg::CNT_W-1:0] r2p_cyc;
  logic                       pulse_done;
  logic                       pg_lost;

  localparam logic [shpe_pkg::CNT_W-1:0] STEP_C =
    shpe_pkg::CNT_W'(shpe_pkg::STEP_CYC);
  localparam logic [shpe_pkg::CNT_W-1:0] MIN_C =
    shpe_pkg::CNT_W'(shpe_pkg::MIN_RST_CYC - 1);

  assign p2r_cyc = shpe_pkg::CNT_W'(bus.p2r_steps) * STEP_C;
  assign r2p_cyc = shpe_pkg::CNT_W'(bus.r2p_steps) * STEP_C;
  assign pulse_done = (pulse_reg >= MIN_C);
  assign pg_lost = (bus.mode == shpe_pkg::MODE_PG) && bus.power_good_n;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || bus.reset_n)
      pulse_reg <= '0;
    else if (!pulse_done)
      pulse_reg <= pulse_reg + 1'b1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_reg    <= shpe_pkg::SEQ_OFF;
      cnt_reg      <= '0;
      bus.power_en <= 1'b0;
      bus.reset_n  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        shpe_pkg::SEQ_OFF:
        begin
          bus.reset_n <= 1'b0;
          cnt_reg     <= '0;
          if (!bus.power_off)
          begin
            bus.power_en <= 1'b1;
            state_reg    <= shpe_pkg::SEQ_PWR_UP;
          end
        end
        shpe_pkg::SEQ_PWR_UP:
        begin
          if (bus.power_off)
          begin
            cnt_reg   <= '0;
            state_reg <= shpe_pkg::SEQ_PWR_DN;
          end
          else if (bus.part_reset || pg_lost)
            cnt_reg <= '0;
          else if (cnt_reg >= p2r_cyc && pulse_done)
          begin
            bus.reset_n <= 1'b1;
            state_reg   <= shpe_pkg::SEQ_ON;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        end
        shpe_pkg::SEQ_ON:
        begin
          // leave released only on a cause
          if (bus.power_off || bus.part_reset || pg_lost)
          begin
            bus.reset_n <= 1'b0;
            cnt_reg     <= '0;
            state_reg   <= bus.power_off ? shpe_pkg::SEQ_PWR_DN
                                         : shpe_pkg::SEQ_PWR_UP;
          end
        end
        default:
        begin
          // reset first, power off after delay
          if (cnt_reg >= r2p_cyc)
          begin
            bus.power_en <= 1'b0;
            state_reg    <= shpe_pkg::SEQ_OFF;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        end
      endcase
    end
  end

  a_off_holds_reset: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) state_reg == shpe_pkg::SEQ_OFF |-> !bus.reset_n)
    else $error("reset released while slot power off");
  a_pe_before_release: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) $rose(bus.reset_n) |-> bus.power_en && $past(bus.power_en,
    2))
    else $error("reset released without power enabled first");
  a_on_stays_released: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) state_reg == shpe_pkg::SEQ_ON |-> bus.reset_n)
    else $error("reset asserted while slot on");
  a_reset_before_off: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) $fell(bus.power_en) |-> !bus.reset_n && $past(!bus.reset_n,
    2))
    else $error("power dropped before reset asserted");
  a_pg_gates_release: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) $rose(bus.reset_n) && bus.mode == shpe_pkg::MODE_PG
    |-> !$past(bus.power_good_n))
    else $error("reset released without power good");
  a_pg_loss_resets: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) bus.reset_n && pg_lost |=> !bus.reset_n)
    else $error("power good loss did not assert reset");
  a_min_pulse_width: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) $rose(bus.reset_n) |-> $past(pulse_reg) >= MIN_C)
    else $error("port reset pulse shorter than minimum");
  a_part_reset_hit: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) bus.reset_n && bus.part_reset |=> !bus.reset_n)
    else $error("partition reset did not assert port reset");

endmodule

// File: hdl/shpe_seq_if.sv
// shpe_seq_if: control and status between the register core and one
// port's power/reset sequencer. assumes one core clock for both ends.
`timescale 1ns/1ps
interface shpe_seq_if;
  logic                       mode;
  logic                       power_off;
  logic [shpe_pkg::DLY_W-1:0] p2r_steps;
  logic [shpe_pkg::DLY_W-1:0] r2p_steps;
  logic                       power_good_n;
  logic                       part_reset;
  logic                       power_en;
  logic                       reset_n;

  modport ctl (output mode, power_off, p2r_steps, r2p_steps,
               power_good_n, part_reset,
               input power_en, reset_n);
  modport seq (input mode, power_off, p2r_steps, r2p_steps,
               power_good_n, part_reset,
               output power_en, reset_n);
endinterface

// File: hdl/shpe_top.sv
// shpe_top: per-port slot power/reset sequencing and hot-plug event
// routing with a classic Wishbone register slave.
// assumes slot event inputs are one-cycle pulses from hot-plug detection.
`timescale 1ns/1ps

module shpe_top #(
  parameter int NPORT = 16,
  parameter int NPART = 4
)
(
  // clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     srst_in,
  // wishbone slave
  input  wire logic                     wb_cyc_in,
  input  wire logic                     wb_stb_in,
  input  wire logic                     wb_we_in,
  input  wire logic [11:2]              wb_adr_in,
  input  wire logic [3:0]               wb_sel_in,
  input  wire logic [31:0]              wb_dat_in,
  output logic                          wb_ack_out,
  output logic [31:0]                   wb_dat_out,
  // slot pins
  output logic [NPORT-1:0]              slot_power_enable_out,
  output logic [NPORT-1:0]              port_reset_out_n,
  input  wire logic [NPORT-1:0]         slot_power_good_n_in,
  input  wire logic [NPORT*6-1:0]       slot_event_in,
  // partition side
  input  wire logic [NPART-1:0]         part_freset_in,
  output logic [NPART-1:0]              part_msi_out,
  output logic [NPART-1:0]              part_intx_out,
  output logic [NPART-1:0]              part_pme_out,
  output logic                          general_event_out_n
);

  initial
  begin
    if (NPORT < 1 || NPORT > 16 || NPART < 1 || NPART > 16)
      $error("shpe_top: port or partition count out of range");
  end

  logic                          ack_reg;
  logic [31:0]                   dat_reg;
  logic                          wr_stb;
  logic                          rd_stb;
  logic [11:0]                   byte_adr;
  logic [3:0]                    port_idx;
  logic [1:0]                    sub_idx;
  logic                          in_ports;
  logic                          mode_reg;
  logic [shpe_pkg::DLY_W-1:0]    p2r_reg;
  logic [shpe_pkg::DLY_W-1:0]    r2p_reg;
  logic                          ge_alt_reg;
  logic [NPORT-1:0]              ge_ctl_reg;
  logic [NPORT-1:0]              ge_sts_reg;
  logic [NPORT-1:0]              ge_evt;
  logic [NPORT-1:0]              port_msi;
  logic [NPORT-1:0]              port_intx;
  logic [NPORT-1:0]              port_pme;
  logic [NPORT*32-1:0]           port_rd;
  logic [NPORT*shpe_pkg::PID_W-1:0] port_part;
  logic [NPORT-1:0]              pe_w;
  logic [NPORT-1:0]              rstn_w;
  logic [31:0]                   rd_word;
  logic [31:0]                   cfg_word;
  logic [31:0]                   cfg_new;
  logic [31:0]                   ge_ctl_new;

  // merge write data into a word by byte enable
  function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[b*8 +: 8] = new_w[b*8 +: 8];
    return res;
  endfunction

  // one-cycle answer; ack drops the cycle after it is given
  assign wr_stb   = wb_cyc_in && wb_stb_in && wb_we_in && !ack_reg;
  assign rd_stb   = wb_cyc_in && wb_stb_in && !wb_we_in && !ack_reg;
  assign byte_adr = {wb_adr_in, 2'b00};
  assign port_idx = byte_adr[7:4];
  assign sub_idx  = byte_adr[3:2];
  assign in_ports = (byte_adr[11:8] == shpe_pkg::OFS_PORT_BASE[11:8])
                    && (32'(port_idx) < NPORT);

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_in && wb_stb_in && !ack_reg;
  end
  assign wb_ack_out = ack_reg;

  assign cfg_word = {7'h00, ge_alt_reg, r2p_reg, p2r_reg, 7'h00, mode_reg};
  assign cfg_new  = merge_sel(cfg_word, wb_dat_in, wb_sel_in);
  assign ge_ctl_new = merge_sel(32'(ge_ctl_reg), wb_dat_in, wb_sel_in);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (byte_adr == shpe_pkg::OFS_HP_CFG)
      rd_word = cfg_word;
    else if (byte_adr == shpe_pkg::OFS_GE_CTL)
      rd_word = 32'(ge_ctl_reg);
    else if (byte_adr == shpe_pkg::OFS_GE_STS)
      rd_word = 32'(ge_sts_reg);
    else if (in_ports)
      rd_word = port_rd[32'(port_idx)*32 +: 32];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      dat_reg <= 32'h0000_0000;
    else if (rd_stb)
      dat_reg <= rd_word;
  end
  assign wb_dat_out = dat_reg;

  // global reset mode and delay fields
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      mode_reg   <= shpe_pkg::MODE_PE;
      p2r_reg    <= shpe_pkg::P2R_RST;
      r2p_reg    <= shpe_pkg::R2P_RST;
      ge_alt_reg <= 1'b0;
    end
    else if (wr_stb && byte_adr == shpe_pkg::OFS_HP_CFG)
    begin
      mode_reg   <= cfg_new[shpe_pkg::CFG_MODE_BIT];
      p2r_reg    <= cfg_new[shpe_pkg::CFG_P2R_LSB +: shpe_pkg::DLY_W];
      r2p_reg    <= cfg_new[shpe_pkg::CFG_R2P_LSB +: shpe_pkg::DLY_W];
      ge_alt_reg <= cfg_new[shpe_pkg::CFG_GEALT_BIT];
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      ge_ctl_reg <= '0;
    else if (wr_stb && byte_adr == shpe_pkg::OFS_GE_CTL)
      ge_ctl_reg <= ge_ctl_new[NPORT-1:0];
  end

  // set only by ports on the general path; set wins over clear
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      ge_sts_reg <= '0;
    else if (wr_stb && byte_adr == shpe_pkg::OFS_GE_STS)
      ge_sts_reg <= (ge_sts_reg & ~(wb_dat_in[NPORT-1:0] &
                     {NPORT{|wb_sel_in}})) | ge_evt;
    else
      ge_sts_reg <= ge_sts_reg | ge_evt;
  end

  // single output, shown only on the alternate function
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      general_event_out_n <= 1'b1;
    else
      general_event_out_n <= !(ge_alt_reg && |ge_sts_reg);
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic [5:0]                 ev_en_reg;
    logic                       hotplug_irq_enable_reg;
    logic                       pwroff_reg;
    logic [5:0]                 sts_reg;
    logic                       msi_en_reg;
    logic                       legacy_irq_disable_reg;
    logic                       wake_reg;
    logic [1:0]                 ps_reg;
    logic [shpe_pkg::PID_W-1:0] part_reg;
    logic                       irq_prev_reg;
    logic [5:0]                 ev;
    logic [5:0]                 new_set;
    logic                       sel_me;
    logic                       ge_mode;
    logic                       irq_cond;
    logic [31:0]                ctl_word;
    logic [31:0]                fn_word;
    logic [31:0]                ctl_new;
    logic [31:0]                fn_new;
    shpe_seq_if                 seq_bus ();

    assign ev     = slot_event_in[p*6 +: 6];
    assign sel_me = wr_stb && in_ports && 32'(port_idx) == p;
    assign ctl_word = {21'h0, pwroff_reg, 3'h0, hotplug_irq_enable_reg, ev_en_reg};
    assign fn_word  = {20'h0, part_reg, 2'h0, ps_reg, 1'b0, wake_reg,
                       legacy_irq_disable_reg, msi_en_reg};
    assign ctl_new  = merge_sel(ctl_word, wb_dat_in, wb_sel_in);
    assign fn_new   = merge_sel(fn_word, wb_dat_in, wb_sel_in);

    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
      begin
        ev_en_reg  <= '0;
        hotplug_irq_enable_reg   <= 1'b0;
        pwroff_reg <= 1'b1;
      end
      else if (sel_me && sub_idx == shpe_pkg::SUB_SLOT_CTL)
      begin
        ev_en_reg  <= ctl_new[5:0];
        hotplug_irq_enable_reg   <= ctl_new[shpe_pkg::CTL_HOTPLUG_IRQ_ENABLE_BIT];
        pwroff_reg <= ctl_new[shpe_pkg::CTL_PWROFF_BIT];
      end
    end

    // status flags keep working on every path; set wins
    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
        sts_reg <= '0;
      else if (sel_me && sub_idx == shpe_pkg::SUB_SLOT_STS && wb_sel_in[0])
        sts_reg <= (sts_reg & ~wb_dat_in[5:0]) | ev;
      else
        sts_reg <= sts_reg | ev;
    end

    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
      begin
        msi_en_reg <= 1'b0;
        legacy_irq_disable_reg  <= 1'b0;
        wake_reg   <= 1'b0;
        ps_reg     <= shpe_pkg::PS_D0;
        part_reg   <= '0;
      end
      else if (sel_me && sub_idx == shpe_pkg::SUB_FUNC)
      begin
        msi_en_reg <= fn_new[shpe_pkg::FN_MSI_BIT];
        legacy_irq_disable_reg  <= fn_new[shpe_pkg::FN_LEGACY_IRQ_DISABLE_BIT];
        wake_reg   <= fn_new[shpe_pkg::FN_WAKE_BIT];
        ps_reg     <= fn_new[shpe_pkg::FN_PS_LSB +: 2];
        part_reg   <= fn_new[shpe_pkg::FN_PART_LSB +: 4];
      end
    end

    // general path only for partition 0 ports
    assign ge_mode  = ge_ctl_reg[p] && part_reg == '0;
    assign new_set  = ev & ~sts_reg & ev_en_reg;
    // level condition, so a flag left over from D3hot fires
    assign irq_cond = |(sts_reg & ev_en_reg) && hotplug_irq_enable_reg &&
                      ps_reg == shpe_pkg::PS_D0 && !ge_mode;

    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
        irq_prev_reg <= 1'b0;
      else
        irq_prev_reg <= irq_cond;
    end

    // message edge when enabled, else legacy level
    assign port_msi[p]  = irq_cond && !irq_prev_reg && msi_en_reg;
    assign port_intx[p] = irq_cond && !msi_en_reg && !legacy_irq_disable_reg;
    // wakeup from D3hot regardless of master enable
    assign port_pme[p]  = |new_set && wake_reg &&
                          ps_reg == shpe_pkg::PS_D3HOT && !ge_mode;
    // general event replaces the other paths
    assign ge_evt[p]    = |new_set && ge_mode;
    assign port_part[p*shpe_pkg::PID_W +: shpe_pkg::PID_W] = part_reg;

    assign seq_bus.mode         = mode_reg;
    assign seq_bus.power_off    = pwroff_reg;
    assign seq_bus.p2r_steps    = p2r_reg;
    assign seq_bus.r2p_steps    = r2p_reg;
    assign seq_bus.power_good_n = slot_power_good_n_in[p];
    assign seq_bus.part_reset   = 32'(part_reg) < NPART &&
                                  part_freset_in[32'(part_reg)];
    assign pe_w[p]   = seq_bus.power_en;
    assign rstn_w[p] = seq_bus.reset_n;

    assign port_rd[p*32 +: 32] =
      (sub_idx == shpe_pkg::SUB_SLOT_CTL) ? ctl_word :
      (sub_idx == shpe_pkg::SUB_SLOT_STS) ? {26'h0, sts_reg} :
      (sub_idx == shpe_pkg::SUB_FUNC)     ? fn_word :
      {29'h0, !slot_power_good_n_in[p], seq_bus.reset_n, seq_bus.power_en};

    shpe_seq u_seq (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .bus        (seq_bus.seq)
    );

    a_ge_sts_cause: assert property (@(posedge sys_clk_in) disable iff
      (srst_in) $rose(ge_sts_reg[p]) |-> $past(ge_mode))
      else $error("general event status set for unconfigured port");
    a_pme_in_d3: assert property (@(posedge sys_clk_in) disable iff
      (srst_in) port_pme[p] |-> ps_reg == shpe_pkg::PS_D3HOT &&
      !port_intx[p] && !port_msi[p])
      else $error("wakeup outside D3hot or with interrupt");
    a_no_irq_masked: assert property (@(posedge sys_clk_in) disable iff
      (srst_in) port_intx[p] |-> hotplug_irq_enable_reg && |(sts_reg & ev_en_reg))
      else $error("legacy interrupt without unmasked flag");
  end

  // slot pins straight from sequencer flops
  assign slot_power_enable_out = pe_w;
  assign port_reset_out_n      = rstn_w;

  // route notifications to the owning partition only
  for (genvar q = 0; q < NPART; q++)
  begin : g_part
    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
      begin
        part_msi_out[q]  <= 1'b0;
        part_intx_out[q] <= 1'b0;
        part_pme_out[q]  <= 1'b0;
      end
      else
      begin
        part_msi_out[q]  <= 1'b0;
        part_intx_out[q] <= 1'b0;
        part_pme_out[q]  <= 1'b0;
        for (int i = 0; i < NPORT; i++)
          if (32'(port_part[i*shpe_pkg::PID_W +: shpe_pkg::PID_W]) == q)
          begin
            if (port_msi[i])
              part_msi_out[q] <= 1'b1;
            if (port_intx[i])
              part_intx_out[q] <= 1'b1;
            if (port_pme[i])
              part_pme_out[q] <= 1'b1;
          end
      end
    end
  end

  a_wb_ack_single: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) ack_reg |=> !ack_reg)
    else $error("ack held longer than one cycle");

endmodule

// File: verif/shpe_slot_model.sv
// shpe_slot_model: slot power controller and card, seen from the pins.
// assumes power good follows power enable after a short ramp.
`timescale 1ns/1ps
module shpe_slot_model
(
  // clock
  input  wire logic sys_clk_in,
  // slot pins
  input  wire logic pwr_en_in,
  input  wire logic fault_in,
  output logic      pwr_good_n_out = 1'b1
);
  int ramp = 0;
  // power good on a direct pin, no expander lag
  always @(posedge sys_clk_in)
  begin
    ramp <= (pwr_en_in && !fault_in) ? ramp + 1 : 0;
    pwr_good_n_out <= !(ramp >= 10);
  end
endmodule

// File: verif/tb_shpe_top.sv
// tb_shpe_top: register-driven bench for one port in partition 0.
// assumes the slot model answers power enable with power good.
`timescale 1ns/1ps
module tb_shpe_top;
  logic c = 0, r = 1, cy = 0, st = 0, we = 0, flt = 1, pr = 0;
  logic ge_n, pg_n, ack;
  logic [9:0] a = 0;
  logic [31:0] d = 0, q, rd;
  logic [5:0] ev = 0;
  logic [0:0] pe, rn, msi, ix, pm;
  int fail_count = 0, check_count = 0, n, m, cyc = 0, msi_n = 0, pm_n = 0;
  shpe_top #(.NPORT(1), .NPART(1)) u_dut (.sys_clk_in(c), .srst_in(r),
    .wb_cyc_in(cy), .wb_stb_in(st), .wb_we_in(we), .wb_adr_in(a),
    .wb_sel_in(4'hf), .wb_dat_in(d), .wb_ack_out(ack), .wb_dat_out(rd),
    .slot_power_enable_out(pe), .port_reset_out_n(rn),
    .slot_power_good_n_in(pg_n), .slot_event_in(ev),
    .part_freset_in(pr), .part_msi_out(msi), .part_intx_out(ix),
    .part_pme_out(pm), .general_event_out_n(ge_n));
  shpe_slot_model u_slot (.sys_clk_in(c), .pwr_en_in(pe[0]),
    .fault_in(flt), .pwr_good_n_out(pg_n));
  initial forever #25 c = ~c;
  always @(posedge c)
  begin
    cyc <= cyc + 1;
    if (msi[0] === 1'b1)
      msi_n <= msi_n + 1;
    if (pm[0] === 1'b1)
      pm_n <= pm_n + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      close_out;
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // waits for ack as long as it takes; only the cycle ceiling ends it
  task automatic wb(input logic w, input logic [9:0] ad,
                    input logic [31:0] dd);
    cy <= 1'b1;
    st <= 1'b1;
    we <= w;
    a <= ad;
    d <= dd;
    do
      @(posedge c);
    while (ack !== 1'b1);
    q = rd;
    cy <= 1'b0;
    st <= 1'b0;
    @(posedge c);
  endtask
  task automatic wait_rn(input logic v);
    n = 0;
    while (rn[0] !== v && n < 5000)
    begin
      @(posedge c);
      n++;
    end
  endtask
  task automatic pulse;
    ev <= 6'h01;
    @(posedge c);
    ev <= 6'h00;
    repeat (10) @(posedge c);
  endtask
  initial
  begin
    repeat (5) @(posedge c);
    r <= 1'b0;
    @(posedge c);
    chk({pe, rn}, 2'b00);
    wb(1, 10'h040, 32'h0000_0041);
    @(posedge c);
    chk({pe, rn}, 2'b10);
    wait_rn(1);
    chk(32'(n >= 3990 && n < 4100), 1);
    pr <= 1'b1;
    repeat (2) @(posedge c);
    chk({pe, rn}, 2'b10);
    pr <= 1'b0;
    wait_rn(1);
    chk(32'(n >= 3990 && n < 4100), 1);
    wb(1, 10'h040, 32'h0000_0441);
    chk({pe, rn}, 2'b10);
    repeat (15) @(posedge c);
    chk(pe, 1);
    repeat (15) @(posedge c);
    chk(pe, 0);
    $display("test power enable mode done");
    wb(1, 10'h000, 32'h0001_0101);
    wb(1, 10'h040, 32'h0000_0041);
    repeat (4100) @(posedge c);
    chk(rn, 0);
    flt <= 1'b0;
    wait_rn(1);
    // model ramp of 11 cycles, then one 20-cycle delay step
    chk(32'(n >= 31 && n <= 34), 1);
    repeat (20) @(posedge c);
    chk(rn, 1);
    flt <= 1'b1;
    repeat (4) @(posedge c);
    chk(rn, 0);
    $display("test power good mode done");
    wb(1, 10'h042, 32'h0000_0001);
    m = msi_n;
    pulse;
    chk(msi_n - m, 1);
    wb(1, 10'h042, 32'h0000_0000);
    chk(ix, 1);
    wb(0, 10'h041, 0);
    chk(q, 32'h0000_0001);
    wb(1, 10'h041, 32'h0000_0001);
    chk(ix, 0);
    wb(1, 10'h040, 32'h0000_0001);
    wb(1, 10'h042, 32'h0000_0035);
    n = pm_n;
    m = msi_n;
    pulse;
    chk(pm_n - n, 1);
    chk(msi_n - m, 0);
    wb(1, 10'h040, 32'h0000_0041);
    m = msi_n;
    wb(1, 10'h042, 32'h0000_0001);
    repeat (4) @(posedge c);
    chk(msi_n - m, 1);
    wb(1, 10'h041, 32'h0000_0001);
    wb(1, 10'h001, 32'h0000_0001);
    wb(1, 10'h000, 32'h0101_0101);
    m = msi_n;
    n = pm_n;
    pulse;
    chk(msi_n - m, 0);
    chk(pm_n - n, 0);
    chk(ge_n, 0);
    wb(0, 10'h002, 0);
    chk(q, 32'h0000_0001);
    wb(0, 10'h041, 0);
    chk(q, 32'h0000_0001);
    wb(1, 10'h000, 32'h0001_0101);
    chk(ge_n, 1);
    $display("test event paths done");
    close_out;
  end
endmodule
